// file: dv/loop_filter_model.sv
`default_nettype none
module loop_filter_model
(
   input wire logic clk_sys_i,
   input wire logic pump_up_pulse_n_i,
   input wire logic pump_down_pulse_n_i,
   output var int tune_o = 0
);
   timeunit 1ns;
   timeprecision 1ps;
   // tuning node charges on up and discharges on down, once per low cycle
   always @(posedge clk_sys_i)
   begin
      if (pump_up_pulse_n_i === 1'b0)
         tune_o <= tune_o + 1;
      else if (pump_down_pulse_n_i === 1'b0)
         tune_o <= tune_o - 1;
   end
endmodule : loop_filter_model
`default_nettype wire

// file: dv/pll_enhancement_and_phase_detect_tb.sv
`default_nettype none
module pll_enhancement_and_phase_detect_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic main_i = 1'b0;
   logic ref_i = 1'b0;
   logic wr = 1'b0;
   logic [7:0] data = 8'h00;
   logic en_n = 1'b1;
   logic modsel_pin = 1'b0;
   logic presc = 1'b0;
   logic up_n, dn_n, node, lock, tout, mout, rout, oe, pd, cload;
   int tune;
   int error_cnt = 0;
   int check_count = 0;

   synth_control uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .divided_main_clock_i(main_i), .divided_reference_clock_i(ref_i),
      .enh_write_i(wr), .enh_data_i(data), .enh_enable_n_i(en_n),
      .modulus_select_i(modsel_pin), .prescaler_out_i(presc),
      .pump_up_pulse_n_o(up_n), .pump_down_pulse_n_o(dn_n),
      .integration_node_o(node), .lock_indicator_o(lock), .test_out_o(tout),
      .divided_main_clock_o(mout), .divided_reference_clock_o(rout),
      .div_clock_oe_o(oe), .power_down_o(pd), .counter_load_o(cload));

   loop_filter_model filt (.clk_sys_i(clk_sys_i), .pump_up_pulse_n_i(up_n),
      .pump_down_pulse_n_i(dn_n), .tune_o(tune));

   initial
   begin
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : tick

   task automatic chk(input logic got, input logic exp, input string msg);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask : chk

   task automatic chk_n(input int got, input int exp, input string msg);
      check_count++;
      if (got != exp)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: %s got %0d exp %0d", $time, msg, got, exp);
      end
   endtask : chk_n

   task automatic wr_enh(input logic [7:0] d);
      data = d;
      tick(3);
      wr = 1'b1;
      tick(4);
      wr = 1'b0;
      tick(5);
   endtask : wr_enh

   // one cycle of the comparison window, counting low pump cycles
   task automatic step(inout int up, inout int dn);
      tick(1);
      if (up_n === 1'b0)
         up++;
      if (dn_n === 1'b0)
         dn++;
      chk(node, ~(up_n & dn_n), "node not nand");
      chk(lock, up_n & dn_n, "lock not and");
   endtask : step

   // first pin rises, second follows k cycles later
   task automatic lead(input int k, input bit main_first, input int exp_up,
         input int exp_dn);
      int up;
      int dn;
      int t0;
      up = 0;
      dn = 0;
      t0 = tune;
      tick(6);
      if (main_first)
         main_i = 1'b1;
      else
         ref_i = 1'b1;
      repeat (k) step(up, dn);
      main_i = 1'b1;
      ref_i = 1'b1;
      repeat (12) step(up, dn);
      main_i = 1'b0;
      ref_i = 1'b0;
      repeat (8) step(up, dn);
      chk_n(up, exp_up, "up low cycles");
      chk_n(dn, exp_dn, "down low cycles");
      chk_n(tune - t0, exp_up - exp_dn, "filter tune step");
   endtask : lead

   task automatic test_src(input logic m, input logic p, input logic e);
      modsel_pin = m;
      presc = p;
      tick(6);
      chk(tout, e, "test output");
   endtask : test_src

   task automatic div_outs(input logic e);
      main_i = 1'b1;
      ref_i = 1'b1;
      tick(6);
      chk(mout, e, "main copy");
      chk(rout, e, "ref copy");
      chk(oe, e, "divided enable");
      main_i = 1'b0;
      ref_i = 1'b0;
      tick(6);
   endtask : div_outs

   task automatic t_detector();
      lead(0, 1'b1, 0, 0);
      lead(2, 1'b1, 0, 2);
      lead(5, 1'b1, 0, 5);
      lead(3, 1'b0, 3, 0);
   endtask : t_detector

   task automatic t_bits();
      en_n = 1'b0;
      wr_enh(8'h07);
      test_src(1'b1, 1'b1, 1'b0);
      chk(pd, 1'b0, "reserved bits act");
      chk(cload, 1'b0, "reserved bits load");
      div_outs(1'b1);
      wr_enh(8'h20);
      chk(cload, 1'b1, "counter load");
      wr_enh(8'h10);
      test_src(1'b1, 1'b0, 1'b1);
      test_src(1'b0, 1'b1, 1'b0);
      wr_enh(8'h40);
      test_src(1'b0, 1'b1, 1'b1);
      test_src(1'b1, 1'b0, 1'b0);
      // both test sources selected: modulus select has priority
      wr_enh(8'h50);
      test_src(1'b1, 1'b0, 1'b1);
      test_src(1'b0, 1'b1, 1'b0);
      wr_enh(8'h80);
      div_outs(1'b0);
   endtask : t_bits

   task automatic t_power();
      en_n = 1'b1;
      wr_enh(8'h28);
      tick(6);
      chk(pd, 1'b0, "power down while disabled");
      chk(cload, 1'b0, "load while disabled");
      en_n = 1'b0;
      tick(6);
      chk(pd, 1'b1, "power down");
      chk(cload, 1'b0, "load in power down");
      div_outs(1'b0);
      lead(4, 1'b1, 0, 0);
      wr_enh(8'h20);
      chk(pd, 1'b0, "write in power down");
      chk(cload, 1'b1, "load after wake");
      lead(3, 1'b1, 0, 3);
   endtask : t_power

   task automatic results();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results

   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      error_cnt++;
      results();
   end

   initial
   begin
      tick(11);
      chk(up_n, 1'b1, "reset up");
      chk(dn_n, 1'b1, "reset down");
      chk(lock, 1'b1, "reset lock");
      chk(node, 1'b0, "reset node");
      chk(pd, 1'b0, "reset power down");
      tick(1);
      rst_n_i = 1'b1;
      tick(4);
      t_detector();
      t_bits();
      t_power();
      results();
   end
endmodule : pll_enhancement_and_phase_detect_tb
`default_nettype wire

// file: logic/pfd_if.sv
`default_nettype none
interface pfd_if;
   logic main_rise;
   logic ref_rise;
   logic enable;
   logic up;
   logic down;
   modport det (input main_rise, input ref_rise, input enable, output up, output down);
   modport ctl (output main_rise, output ref_rise, output enable, input up, input down);
endinterface : pfd_if
`default_nettype wire

// file: logic/phase_freq_detector.sv
`default_nettype none
module phase_freq_detector
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   pfd_if.det pfd
);
   synth_ctl_pkg::pfd_state_e state;
   synth_ctl_pkg::pfd_state_e next_state;

   // a lead holds its request until the lagging edge arrives, so width tracks offset
   always_comb
   begin
      next_state = state;
      if (!pfd.enable)
      begin
         next_state = synth_ctl_pkg::PFD_IDLE;
      end
      else
      begin
         case (state)
            synth_ctl_pkg::PFD_IDLE:
            begin
               if (pfd.main_rise && !pfd.ref_rise)
               begin
                  next_state = synth_ctl_pkg::PFD_DOWN;
               end
               else if (pfd.ref_rise && !pfd.main_rise)
               begin
                  next_state = synth_ctl_pkg::PFD_UP;
               end
            end
            synth_ctl_pkg::PFD_UP:
            begin
               if (pfd.main_rise)
               begin
                  next_state = synth_ctl_pkg::PFD_IDLE;
               end
            end
            synth_ctl_pkg::PFD_DOWN:
            begin
               if (pfd.ref_rise)
               begin
                  next_state = synth_ctl_pkg::PFD_IDLE;
               end
            end
            default:
            begin
               next_state = synth_ctl_pkg::PFD_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         state <= synth_ctl_pkg::PFD_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign pfd.up = (state == synth_ctl_pkg::PFD_UP);
   assign pfd.down = (state == synth_ctl_pkg::PFD_DOWN);

   sequence s_main_leads;
      pfd.enable && pfd.main_rise && !pfd.ref_rise && state == synth_ctl_pkg::PFD_IDLE;
   endsequence

   sequence s_ref_leads;
      pfd.enable && pfd.ref_rise && !pfd.main_rise && state == synth_ctl_pkg::PFD_IDLE;
   endsequence

   a_down_on_lead: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_main_leads |=> pfd.down && !pfd.up)
      else $error("main lead did not raise down request");

   a_up_on_lead: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_ref_leads |=> pfd.up && !pfd.down)
      else $error("reference lead did not raise up request");

   a_down_held: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      pfd.down && pfd.enable && !pfd.ref_rise |=> pfd.down)
      else $error("down request ended before reference edge");

   a_up_held: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      pfd.up && pfd.enable && !pfd.main_rise |=> pfd.up)
      else $error("up request ended before main edge");
endmodule : phase_freq_detector
`default_nettype wire

// file: logic/synth_control.sv
`default_nettype none
// Operation
// - enhancement bits active when set high
// - power down stops all but programming
// - bit 4 routes modulus select out
// - bit 5 reloads counters continuously
// - bit 6 routes prescaler output out
// - bits act only while enable low
// - detector acts on both rising edges
// - main lead pulses down output low
// - reference lead pulses up output low
// - pulse width follows phase offset
// - integration node is NAND of pulses
// - lock indicator is AND of pulses
module synth_control
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic divided_main_clock_i,
   input wire logic divided_reference_clock_i,
   input wire logic enh_write_i,
   input wire logic [7:0] enh_data_i,
   input wire logic enh_enable_n_i,
   input wire logic modulus_select_i,
   input wire logic prescaler_out_i,
   output logic pump_up_pulse_n_o,
   output logic pump_down_pulse_n_o,
   output logic integration_node_o,
   output logic lock_indicator_o,
   output logic test_out_o,
   output logic divided_main_clock_o,
   output logic divided_reference_clock_o,
   output logic div_clock_oe_o,
   output logic power_down_o,
   output logic counter_load_o
);
   localparam int unsigned NPIN = synth_ctl_pkg::PIN_COUNT;

   logic [NPIN-1:0] pins_raw;
   logic [NPIN-1:0] pins_meta;
   logic [NPIN-1:0] pins_sync;
   logic main_sync;
   logic ref_sync;
   logic write_sync;
   logic modsel_sync;
   logic presc_sync;
   logic enh_n_sync;
   logic [7:0] data_sync;
   logic main_prev;
   logic ref_prev;
   logic write_prev;
   logic write_rise;
   logic [7:0] enhancement_control;
   logic [7:0] enh_eff;
   logic pd_eff;
   logic modsel_sel;
   logic presc_sel;
   logic div_off;
   logic load_sel;

   pfd_if pfd ();

   assign pins_raw = {enh_data_i, enh_enable_n_i, prescaler_out_i, modulus_select_i,
                      enh_write_i, divided_reference_clock_i, divided_main_clock_i};

   // two-stage synchronisers, one per pin
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++)
      begin : g_sync
         always_ff @(posedge clk_sys_i)
         begin
            if (!rst_n_i)
            begin
               pins_meta[gi] <= synth_ctl_pkg::SYNC_IDLE[gi];
               pins_sync[gi] <= synth_ctl_pkg::SYNC_IDLE[gi];
            end
            else
            begin
               pins_meta[gi] <= pins_raw[gi];
               pins_sync[gi] <= pins_meta[gi];
            end
         end
      end
   endgenerate

   assign main_sync = pins_sync[synth_ctl_pkg::PIN_MAIN];
   assign ref_sync = pins_sync[synth_ctl_pkg::PIN_REF];
   assign write_sync = pins_sync[synth_ctl_pkg::PIN_WRITE];
   assign modsel_sync = pins_sync[synth_ctl_pkg::PIN_MODSEL];
   assign presc_sync = pins_sync[synth_ctl_pkg::PIN_PRESC];
   assign enh_n_sync = pins_sync[synth_ctl_pkg::PIN_ENH_N];
   assign data_sync = pins_sync[synth_ctl_pkg::PIN_DATA_LSB +: synth_ctl_pkg::ENH_WIDTH];

   // edge history of the synchronised main, reference and write pins
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         main_prev <= 1'b0;
         ref_prev <= 1'b0;
         write_prev <= 1'b0;
      end
      else
      begin
         main_prev <= main_sync;
         ref_prev <= ref_sync;
         write_prev <= write_sync;
      end
   end

   assign write_rise = write_sync && !write_prev;

   // the write strobe keeps working in power down
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         enhancement_control <= synth_ctl_pkg::ENH_RESET;
      end
      else if (write_rise)
      begin
         enhancement_control <= data_sync;
      end
   end

   // bits only count while the enable pin is low
   assign enh_eff = enh_enable_n_sync_gate(enhancement_control, enh_n_sync);

   function automatic logic [7:0] enh_enable_n_sync_gate(input logic [7:0] value,
                                                         input logic enable_n);
      logic [7:0] result;
      result = enable_n ? synth_ctl_pkg::ENH_RESET : value;
      // reserved positions carry no function
      result[synth_ctl_pkg::ENH_RSVD0_BIT] = 1'b0;
      result[synth_ctl_pkg::ENH_RSVD1_BIT] = 1'b0;
      result[synth_ctl_pkg::ENH_RSVD2_BIT] = 1'b0;
      return result;
   endfunction : enh_enable_n_sync_gate

   // each function is active on a one
   assign pd_eff = enh_eff[synth_ctl_pkg::ENH_POWER_DOWN_BIT];
   assign modsel_sel = enh_eff[synth_ctl_pkg::ENH_MODSEL_OUT_BIT];
   assign presc_sel = enh_eff[synth_ctl_pkg::ENH_PRESC_OUT_BIT];
   assign div_off = enh_eff[synth_ctl_pkg::ENH_DIV_OUT_OFF_BIT];
   assign load_sel = enh_eff[synth_ctl_pkg::ENH_COUNTER_LOAD_BIT];

   assign pfd.main_rise = main_sync && !main_prev;
   assign pfd.ref_rise = ref_sync && !ref_prev;
   assign pfd.enable = !pd_eff;

   phase_freq_detector u_pfd
   (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .pfd(pfd.det)
   );

   // pump outputs, high while no request is pending
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         pump_up_pulse_n_o <= 1'b1;
         pump_down_pulse_n_o <= 1'b1;
      end
      else
      begin
         pump_up_pulse_n_o <= !pfd.up;
         pump_down_pulse_n_o <= !pfd.down;
      end
   end

   // integration node and lock track the same requests as the pumps
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         integration_node_o <= 1'b0;
         lock_indicator_o <= 1'b1;
      end
      else
      begin
         integration_node_o <= !(!pfd.up && !pfd.down);
         lock_indicator_o <= !pfd.up && !pfd.down;
      end
   end

   // test output, modulus select has priority over prescaler
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         test_out_o <= 1'b0;
      end
      else if (pd_eff)
      begin
         test_out_o <= 1'b0;
      end
      else if (modsel_sel)
      begin
         test_out_o <= modsel_sync;
      end
      else if (presc_sel)
      begin
         test_out_o <= presc_sync;
      end
      else
      begin
         test_out_o <= 1'b0;
      end
   end

   // divided clock outputs and their enable
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         div_clock_oe_o <= 1'b0;
         divided_main_clock_o <= 1'b0;
         divided_reference_clock_o <= 1'b0;
      end
      else
      begin
         div_clock_oe_o <= !div_off && !pd_eff;
         divided_main_clock_o <= main_sync && !div_off && !pd_eff;
         divided_reference_clock_o <= ref_sync && !div_off && !pd_eff;
      end
   end

   // power down and continuous counter load levels
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         power_down_o <= 1'b0;
         counter_load_o <= 1'b0;
      end
      else
      begin
         power_down_o <= pd_eff;
         counter_load_o <= load_sel && !pd_eff;
      end
   end

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_power_down_held;
      pd_eff [*2];
   endsequence

   sequence s_strobe_rise;
      write_sync && !write_prev;
   endsequence

   a_power_down_quiet: assert property (
      s_power_down_held |=> pump_up_pulse_n_o && pump_down_pulse_n_o && !test_out_o)
      else $error("pumps or test output active in power down");

   a_register_load: assert property (
      s_strobe_rise |=> enhancement_control == $past(data_sync))
      else $error("enhancement register did not capture strobe data");

   a_modsel_route: assert property (
      modsel_sel && !pd_eff |=> test_out_o == $past(modsel_sync))
      else $error("test output does not follow modulus select");

   a_presc_route: assert property (
      presc_sel && !modsel_sel && !pd_eff |=> test_out_o == $past(presc_sync))
      else $error("test output does not follow prescaler output");

   a_counter_load: assert property (
      load_sel && !pd_eff |=> counter_load_o)
      else $error("counter load level missing");

   a_div_out_off: assert property (
      div_off |=> !div_clock_oe_o && !divided_main_clock_o && !divided_reference_clock_o)
      else $error("divided outputs active while disabled");

   a_enable_gate: assert property (
      enh_n_sync |=> !power_down_o && !counter_load_o && div_clock_oe_o)
      else $error("enhancement bits acted while enable high");

   a_node_nand: assert property (
      integration_node_o == !(pump_up_pulse_n_o && pump_down_pulse_n_o))
      else $error("integration node is not nand of pump outputs");

   a_lock_and: assert property (
      lock_indicator_o == (pump_up_pulse_n_o && pump_down_pulse_n_o))
      else $error("lock indicator is not and of pump outputs");

   a_idle_high: assert property (
      !pfd.up && !pfd.down |=> pump_up_pulse_n_o && pump_down_pulse_n_o)
      else $error("pump output low with no lead pending");
endmodule : synth_control
`default_nettype wire

// file: logic/synth_ctl_pkg.sv
`default_nettype none
package synth_ctl_pkg;
   // enhancement control bit positions
   localparam int unsigned ENH_WIDTH = 8;
   localparam int unsigned ENH_RSVD0_BIT = 0;
   localparam int unsigned ENH_RSVD1_BIT = 1;
   localparam int unsigned ENH_RSVD2_BIT = 2;
   localparam int unsigned ENH_POWER_DOWN_BIT = 3;
   localparam int unsigned ENH_MODSEL_OUT_BIT = 4;
   localparam int unsigned ENH_COUNTER_LOAD_BIT = 5;
   localparam int unsigned ENH_PRESC_OUT_BIT = 6;
   localparam int unsigned ENH_DIV_OUT_OFF_BIT = 7;
   localparam logic [7:0] ENH_RESET = 8'h00;
   // pin synchroniser layout
   localparam int unsigned SYNC_STAGES = 2;
   localparam int unsigned PIN_MAIN = 0;
   localparam int unsigned PIN_REF = 1;
   localparam int unsigned PIN_WRITE = 2;
   localparam int unsigned PIN_MODSEL = 3;
   localparam int unsigned PIN_PRESC = 4;
   localparam int unsigned PIN_ENH_N = 5;
   localparam int unsigned PIN_DATA_LSB = 6;
   localparam int unsigned PIN_COUNT = PIN_DATA_LSB + ENH_WIDTH;
   localparam logic [PIN_COUNT-1:0] SYNC_RESET = 14'h0000;
   localparam logic [PIN_COUNT-1:0] SYNC_IDLE = 14'h0020;

   typedef enum logic [1:0] {
      PFD_IDLE = 2'b00,
      PFD_UP = 2'b01,
      PFD_DOWN = 2'b10
   } pfd_state_e;
endpackage : synth_ctl_pkg
`default_nettype wire
